// file: core/cmc_pkg.sv
// Purpose: shared constants for the display memory contention block
// Assumes: single 10 MHz system clock, synchronous design
// Notes:   no software-reachable registers; control arrives on ports
package cmc_pkg;
    localparam int             CMC_ADDR_W       = 14;               // display address width
    localparam int             CMC_STATUS_W     = 8;                // status byte width
    localparam int             CMC_RETRACE_BIT  = 5;                // vertical retrace flag position
    localparam int             CMC_READY_BIT    = 7;                // update ready flag position
    localparam logic [13:0]    CMC_UPD_RESET    = 14'h0000;         // update address after reset
    localparam logic [13:0]    CMC_ADDR_RESET   = 14'h0000;         // address lines after reset
    localparam int             CMC_CLK_MHZ      = 10;               // system clock rate
    localparam int             CMC_STB_NS       = 100;              // strobe length, one character clock at most
    localparam int             CMC_STB_CYC      = (CMC_STB_NS * CMC_CLK_MHZ) / 1000 < 1 ? 1
                                                  : (CMC_STB_NS * CMC_CLK_MHZ) / 1000; // cycles
    typedef enum logic [1:0] {
        CMC_MODE_SHARED_PRIO,                                       // processor priority / vblank polling
        CMC_MODE_SHARED_ILV,                                        // shared phase interleave
        CMC_MODE_TRANS_ILV,                                         // transparent interleave
        CMC_MODE_TRANS_BLANK                                        // transparent during blanking
    } cmc_mode_t;
endpackage

// file: core/cmc_sync2.sv
// Purpose: two flop synchroniser for pin inputs
// Assumes: input is asynchronous to sys_clk
// Notes:   first stage is read only by the second
`timescale 1ns/1ps
module cmc_sync2 (
    input  wire logic sys_clk,   // system clock
    input  wire logic rst_b,     // async reset, active low
    input  wire logic d_in,      // asynchronous level
    output logic      q_out      // synchronised level
);
    logic meta_reg;              // first stage
    // ****************************************
    // two stage capture
    // ****************************************
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            meta_reg <= 1'b0;
            q_out    <= 1'b0;
        end else begin
            meta_reg <= d_in;
            q_out    <= meta_reg;
        end
    end
endmodule

// file: core/cmc_contention.sv
// Purpose: display memory address contention for a CRT controller
// Assumes: refresh address, blanking and bus phase come from the timing core
// Notes:   bus enable and reset release are synchronised, other inputs are same domain; outputs registered
// Contract
// (R1) shared interleave: refresh address while enable low
// (R2) outside mux puts processor address phase two
// (R3) outside mux gives processor priority immediately
// (R4) status bit 5 reads one in vblank
// (R5) processor polls bit 5 before accessing memory
// (R6) transparent mode: controller drives all address lines
// (R7) transparent interleave: update address every phase two
// (R8) processor loads update pair before access
// (R9) blanking mode: update address only during blanking
// (R10) strobe high exactly while update address shown
// (R11) outside latch holds data until strobe
// (R12) update pair holds 14-bit address
// (R13) update address increments after each access
// (R14) dummy location access requests update, sets ready
// (R15) strobe on raster top line, active high
// (R16) blanking mode: one character period per request
`timescale 1ns/1ps
module cmc_contention
    import cmc_pkg::*;
(
    input  wire logic                       sys_clk,       // 10 MHz system clock
    input  wire logic                       rst_b,         // async reset, active low
    input  wire cmc_pkg::cmc_mode_t         mode,          // contention scheme, static
    input  wire logic                       bus_enable,    // bus enable clock pin, low = phase one
    input  wire logic                       char_tick,     // character clock period start, same domain
    input  wire logic                       hblank,        // horizontal blanking, same domain
    input  wire logic                       vblank,        // vertical blanking, same domain
    input  wire logic [cmc_pkg::CMC_ADDR_W-1:0] refresh_addr, // refresh address from scan counter
    input  wire logic [4:0]                 raster_addr,   // raster address from scan counter
    input  wire logic                       upd_load_hi,   // write strobe high update byte
    input  wire logic                       upd_load_lo,   // write strobe low update byte
    input  wire logic [7:0]                 upd_wdata,     // processor write data
    input  wire logic                       dummy_access,  // access to dummy update location
    input  wire logic                       status_rd,     // status read, clears ready
    output logic [cmc_pkg::CMC_ADDR_W-1:0]  display_memory_address_lines, // memory address out
    output logic                            raster_address_top_line,      // raster top or strobe
    output logic [3:0]                      raster_low,    // raster lines 0..3
    output logic                            update_strobe, // separate copy of strobe
    output logic [cmc_pkg::CMC_STATUS_W-1:0] status        // status byte
);
    import cmc_pkg::*;

    // ****************************************
    // reset release and pin synchronisers
    // ****************************************
    logic rst_s1_reg;                      // reset release stage one
    logic rst_sync_b;                      // released reset copy
    logic phase_two;                       // synchronised bus enable
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            rst_s1_reg <= 1'b0;
            rst_sync_b <= 1'b0;
        end else begin
            rst_s1_reg <= 1'b1;
            rst_sync_b <= rst_s1_reg;
        end
    end
    cmc_sync2 u_sync_en (
        .sys_clk (sys_clk),
        .rst_b   (rst_sync_b),
        .d_in    (bus_enable),
        .q_out   (phase_two)
    );

    // ****************************************
    // mode decode
    // ****************************************
    wire  transparent = (mode == CMC_MODE_TRANS_ILV) || (mode == CMC_MODE_TRANS_BLANK); // see (R6) (R15)
    wire  blanking    = hblank || vblank;                // either retrace interval
    logic [CMC_ADDR_W-1:0] upd_addr_reg;                 // update address pair, see (R12)
    logic [CMC_ADDR_W-1:0] upd_addr_next;                // next update address
    logic                  pending_reg;                  // blanking request outstanding
    logic                  pending_next;                 // next pending
    logic                  ready_reg;                    // update ready flag
    logic                  ready_next;                   // next ready
    logic [CMC_ADDR_W-1:0] addr_next;                    // next address lines
    logic                  stb_next;                     // next strobe

    // interleave phase two slot, every second bus phase
    wire  ilv_slot   = (mode == CMC_MODE_TRANS_ILV) && phase_two;            // see (R7)
    // blanking slot only at a character tick in retrace with a request
    wire  blank_slot = (mode == CMC_MODE_TRANS_BLANK) && pending_reg
                       && blanking && char_tick;                             // see (R9) (R16)
    // a slot stays open for the rest of its character period, never past the end of retrace
    wire  hold_slot  = (mode == CMC_MODE_TRANS_BLANK) && update_strobe && !char_tick
                       && blanking;                                          // see (R9) (R16)
    wire  show_upd   = ilv_slot || blank_slot || hold_slot;                  // update on lines
    wire  done_acc   = blank_slot || (ilv_slot && dummy_access);             // access completes

    // ****************************************
    // next-state selection
    // ****************************************
    always_comb begin
        upd_addr_next = upd_addr_reg;
        pending_next  = pending_reg;
        ready_next    = ready_reg;
        if (status_rd) begin
            ready_next = 1'b0;                 // read clears, set below wins
        end
        if (upd_load_hi) begin                 // processor loads pair, see (R8)
            upd_addr_next[13:8] = upd_wdata[5:0];
        end else if (upd_load_lo) begin
            upd_addr_next[7:0] = upd_wdata;
        end else if (done_acc && transparent) begin
            upd_addr_next = upd_addr_reg + 14'h0001;         // see (R13)
        end
        if (dummy_access && transparent) begin // see (R14)
            ready_next   = 1'b1;
            pending_next = (mode == CMC_MODE_TRANS_BLANK);
        end else if (blank_slot) begin
            pending_next = 1'b0;               // one period per request, see (R16)
        end
        // shared interleave puts refresh on lines in both phases; outside mux takes phase two
        // a held slot keeps the address it opened with; the pair has already stepped on
        if (hold_slot) begin
            addr_next = display_memory_address_lines;        // see (R16)
        end else if (show_upd) begin
            addr_next = upd_addr_reg;                        // see (R6)
        end else begin
            addr_next = refresh_addr;                        // see (R1)
        end
        stb_next  = show_upd && transparent;                 // see (R10)
    end

    // ****************************************
    // state registers
    // ****************************************
    always_ff @(posedge sys_clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            upd_addr_reg <= CMC_UPD_RESET;
            pending_reg  <= 1'b0;
            ready_reg    <= 1'b0;
        end else begin
            upd_addr_reg <= upd_addr_next;
            pending_reg  <= pending_next;
            ready_reg    <= ready_next;
        end
    end

    // ****************************************
    // registered outputs
    // ****************************************
    always_ff @(posedge sys_clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            display_memory_address_lines <= CMC_ADDR_RESET;
            raster_address_top_line      <= 1'b0;
            raster_low                   <= 4'h0;
            update_strobe                <= 1'b0;
            status                       <= 8'h00;
        end else begin
            display_memory_address_lines <= addr_next;
            // top raster line doubles as active-high strobe, see (R15)
            raster_address_top_line      <= transparent ? stb_next : raster_addr[4];
            raster_low                   <= raster_addr[3:0];
            update_strobe                <= stb_next;
            status                       <= {ready_next, 1'b0, vblank, 5'h00}; // see (R4)
        end
    end

    // ****************************************
    // checks
    // ****************************************
    property p_retrace_flag;
        @(posedge sys_clk) disable iff (!rst_sync_b)
        // the release edge itself still loads reset values, so start one edge later
        rst_sync_b |=> (status[CMC_RETRACE_BIT] == $past(vblank));
    endproperty
    a_retrace_flag: assert property (p_retrace_flag) else $error("retrace flag wrong"); // see (R4)
    property p_phase_one_refresh;
        @(posedge sys_clk) disable iff (!rst_sync_b)
        (rst_sync_b && mode != CMC_MODE_TRANS_BLANK && !phase_two)
        |=> (display_memory_address_lines == $past(refresh_addr));
    endproperty
    a_phase_one_refresh: assert property (p_phase_one_refresh) else $error("phase one not refresh"); // see (R1)
    property p_ilv_update;
        @(posedge sys_clk) disable iff (!rst_sync_b)
        (mode == CMC_MODE_TRANS_ILV && phase_two && !upd_load_hi && !upd_load_lo)
        |=> (display_memory_address_lines == $past(upd_addr_reg)) && update_strobe;
    endproperty
    a_ilv_update: assert property (p_ilv_update) else $error("phase two not update"); // see (R7)
    property p_no_active_update;
        @(posedge sys_clk) disable iff (!rst_sync_b)
        (mode == CMC_MODE_TRANS_BLANK && !blanking) |=> !update_strobe;
    endproperty
    a_no_active_update: assert property (p_no_active_update) else $error("update in active display"); // see (R9)
    property p_strobe_pin;
        @(posedge sys_clk) disable iff (!rst_sync_b)
        transparent |-> (raster_address_top_line == update_strobe);
    endproperty
    a_strobe_pin: assert property (p_strobe_pin) else $error("strobe pin mismatch"); // see (R10) (R15)
    property p_increment;
        @(posedge sys_clk) disable iff (!rst_sync_b)
        (blank_slot && !upd_load_hi && !upd_load_lo) |=> (upd_addr_reg == $past(upd_addr_reg) + 14'h0001);
    endproperty
    a_increment: assert property (p_increment) else $error("no increment"); // see (R13)
    property p_dummy_ready;
        @(posedge sys_clk) disable iff (!rst_sync_b)
        (dummy_access && transparent) |=> status[CMC_READY_BIT];
    endproperty
    a_dummy_ready: assert property (p_dummy_ready) else $error("ready not set"); // see (R14)
    property p_one_period;
        @(posedge sys_clk) disable iff (!rst_sync_b)
        (mode == CMC_MODE_TRANS_BLANK && blank_slot && !dummy_access) |=> !pending_reg;
    endproperty
    a_one_period: assert property (p_one_period) else $error("request not retired"); // see (R16)
    property p_hold_address;
        @(posedge sys_clk) disable iff (!rst_sync_b)
        (mode == CMC_MODE_TRANS_BLANK && update_strobe && blanking && !char_tick)
        |=> update_strobe && $stable(display_memory_address_lines);
    endproperty
    a_hold_address: assert property (p_hold_address) else $error("held slot moved"); // see (R16)
    property p_load_hi;
        @(posedge sys_clk) disable iff (!rst_sync_b)
        upd_load_hi |=> (upd_addr_reg[13:8] == $past(upd_wdata[5:0]));
    endproperty
    a_load_hi: assert property (p_load_hi) else $error("high update byte not loaded"); // see (R12)
    property p_load_lo;
        @(posedge sys_clk) disable iff (!rst_sync_b)
        (upd_load_lo && !upd_load_hi) |=> (upd_addr_reg[7:0] == $past(upd_wdata));
    endproperty
    a_load_lo: assert property (p_load_lo) else $error("low update byte not loaded"); // see (R12)
    property p_ready_clear;
        @(posedge sys_clk) disable iff (!rst_sync_b)
        (rst_sync_b && status_rd && !(dummy_access && transparent)) |=> !status[CMC_READY_BIT];
    endproperty
    a_ready_clear: assert property (p_ready_clear) else $error("ready not cleared"); // see (R14)
    c_ilv:   cover property (@(posedge sys_clk) mode == CMC_MODE_TRANS_ILV && update_strobe);
    c_blank: cover property (@(posedge sys_clk) blank_slot);
    c_ready: cover property (@(posedge sys_clk) status[CMC_READY_BIT] && status_rd);
    c_hold:  cover property (@(posedge sys_clk) hold_slot);
endmodule

// file: verif/cmc_mem_side.sv
// Purpose: processor side and outside address mux around the contention block
// Assumes: request and bus enable are levels in the sys_clk domain
// Notes:   behavioural; the latch stands in for the outside data hold register
`timescale 1ns/1ps
module cmc_mem_side (
    input  wire logic        sys_clk,   // system clock
    input  wire logic        trans,     // transparent scheme chosen
    input  wire logic        proc_req,  // processor wants memory
    input  wire logic        phase_two, // bus enable high
    input  wire logic [13:0] proc_addr, // processor address
    input  wire logic [13:0] crtc_addr, // controller address lines
    input  wire logic [7:0]  proc_data, // character written
    input  wire logic        proc_wr,   // write pulse
    output logic      [13:0] mem_addr,  // address seen by memory
    output logic      [7:0]  held_data  // latched character
);
    // no outside mux in transparent schemes; otherwise processor wins at once and owns phase two
    assign mem_addr = trans ? crtc_addr : ((proc_req || phase_two) ? proc_addr : crtc_addr);
    // hold the character until the strobe, so the processor never waits for blanking
    always_ff @(posedge sys_clk) begin
        if (proc_wr) begin
            held_data <= proc_data;
        end
    end
endmodule

// file: verif/crtc_display_memory_contention_tb.sv
// Purpose: self-checking bench for the contention block
// Assumes: inputs change on the falling edge, outputs one cycle after sampling
// Notes:   each mode is entered from a fresh reset, since mode must stay static
`timescale 1ns/1ps
module crtc_display_memory_contention_tb;
    import cmc_pkg::*;
    logic sys_clk = 1'b0, rst_b = 1'b0, bus_enable = 1'b0, char_tick = 1'b0;
    logic hblank = 1'b0, vblank = 1'b0, upd_load_hi = 1'b0, upd_load_lo = 1'b0;
    logic dummy_access = 1'b0, status_rd = 1'b0, proc_req = 1'b0, rtop, strobe;
    cmc_mode_t             mode = CMC_MODE_SHARED_PRIO; // scheme under test
    logic [CMC_ADDR_W-1:0] refresh_addr = 14'h1F0E;     // scan address
    logic [CMC_ADDR_W-1:0] mda, mem_addr;               // design and memory address
    logic [4:0]            raster_addr = 5'h13;         // top bit set on purpose
    logic [7:0]            upd_wdata = 8'h00, status;   // write data, status byte
    logic [3:0]            rlow;                        // low raster lines
    logic [7:0]            held;                        // character held outside
    int                    n_fail = 0, comparisons = 0; // score
    always #50 sys_clk = ~sys_clk;
    cmc_contention dut_u (.sys_clk(sys_clk), .rst_b(rst_b), .mode(mode), .bus_enable(bus_enable),
        .char_tick(char_tick), .hblank(hblank), .vblank(vblank), .refresh_addr(refresh_addr),
        .raster_addr(raster_addr), .upd_load_hi(upd_load_hi), .upd_load_lo(upd_load_lo),
        .upd_wdata(upd_wdata), .dummy_access(dummy_access), .status_rd(status_rd),
        .display_memory_address_lines(mda), .raster_address_top_line(rtop), .raster_low(rlow),
        .update_strobe(strobe), .status(status));
    cmc_mem_side ms_u (.sys_clk(sys_clk), .trans(mode[1]), .proc_req(proc_req), .phase_two(bus_enable),
        .proc_addr(14'h0AAA), .crtc_addr(mda), .proc_data(upd_wdata), .proc_wr(upd_load_lo),
        .mem_addr(mem_addr), .held_data(held));
    // ****************************************
    // shared tasks
    // ****************************************
    task automatic tick(input int n);
        repeat (n) @(negedge sys_clk);
    endtask
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic do_reset(input cmc_mode_t m);
        rst_b = 1'b0;
        mode = m;
        tick(6);
        rst_b = 1'b1;
        tick(4);
    endtask
    // load both bytes when load is set, then hit the dummy location
    task automatic request(input logic [13:0] a, input bit load);
        if (load) begin
            upd_load_hi = 1'b1;
            upd_wdata = {2'b00, a[13:8]};
            tick(1);
            upd_load_hi = 1'b0;
            upd_load_lo = 1'b1;
            upd_wdata = a[7:0];
            tick(1);
            upd_load_lo = 1'b0;
        end
        dummy_access = 1'b1;
        tick(1);
        dummy_access = 1'b0;
        tick(1);
    endtask
    // one character clock start, then wait for its registered answer
    task automatic char_pulse();
        char_tick = 1'b1;
        tick(1);
        char_tick = 1'b0;
        tick(2);
    endtask
    task automatic complete_run();
        if (n_fail == 0 && comparisons > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // ****************************************
    // scenarios
    // ****************************************
    task automatic shared_modes();
        do_reset(CMC_MODE_SHARED_ILV);
        check(mda, 14'h1F0E);
        check(rtop, 1'b1);
        check(rlow, 4'h3);
        bus_enable = 1'b1;
        tick(4);
        check(mem_addr, 14'h0AAA);
        check(mda, 14'h1F0E);
        bus_enable = 1'b0;
        request(14'h0155, 1'b1);
        check(status[7], 1'b0);
        do_reset(CMC_MODE_SHARED_PRIO);
        check(mem_addr, 14'h1F0E);
        vblank = 1'b1;
        tick(2);
        check(status, 8'h20);
        // processor polls the retrace flag and only then asks for memory
        proc_req = status[5];
        tick(1);
        check(mem_addr, 14'h0AAA);
        proc_req = 1'b0;
        vblank = 1'b0;
        tick(2);
        check(status[5], 1'b0);
    endtask
    task automatic blank_mode();
        do_reset(CMC_MODE_TRANS_BLANK);
        request(14'h2A5C, 1'b1);
        check(status[7], 1'b1);
        status_rd = 1'b1;
        tick(1);
        status_rd = 1'b0;
        check(status[7], 1'b0);
        char_pulse();
        check({strobe, rtop}, 2'b00);
        hblank = 1'b1;
        char_pulse();
        check({strobe, rtop}, 2'b11);
        check(mda, 14'h2A5C);
        check(mem_addr, 14'h2A5C);
        check(held, 8'h5C);
        char_pulse();
        check(strobe, 1'b0);
        hblank = 1'b0;
        vblank = 1'b1;
        request(14'h0000, 1'b0);
        char_pulse();
        check(mda, 14'h2A5D);
        check(strobe, 1'b1);
        vblank = 1'b0;
        tick(1);
        check(strobe, 1'b0);
    endtask
    task automatic ilv_mode();
        do_reset(CMC_MODE_TRANS_ILV);
        request(14'h3FFF, 1'b1);
        bus_enable = 1'b1;
        tick(4);
        check(mda, 14'h3FFF);
        check(strobe, 1'b1);
        // dummy access in phase two together with a status read: set wins, address wraps
        dummy_access = 1'b1;
        status_rd = 1'b1;
        tick(1);
        dummy_access = 1'b0;
        status_rd = 1'b0;
        tick(1);
        check(mda, 14'h0000);
        check(status[7], 1'b1);
        bus_enable = 1'b0;
        tick(4);
        check(strobe, 1'b0);
        check(mda, 14'h1F0E);
    endtask
    initial begin
        do_reset(CMC_MODE_SHARED_PRIO);
        check(status, 8'h00);
        shared_modes();
        blank_mode();
        ilv_mode();
        complete_run();
    end
    // cut a hang short, far beyond the hundred or so cycles the tests need
    initial begin
        #500000;
        n_fail++;
        complete_run();
    end
endmodule
